// ### src/pdt_pkg.sv
// constants for the cell protection registers
package pdt_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MS_PERIOD_NS   = 1000000;
    localparam int MS_CYCLES      = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BUS_RESET_US   = 120;
    localparam int BUS_RESET_CYC  = BUS_RESET_US * 1000 / CLK_PERIOD_NS;
    localparam int MS_W           = 13;
    localparam logic [MS_W-1:0] OCD_BASE_MS = 13'h0002;
    localparam logic [MS_W-1:0] UVD_BASE_MS = 13'h0020;
    localparam logic [MS_W-1:0] OVD_BASE_MS = 13'h0200;
    localparam logic [MS_W-1:0] REL_BASE_MS = 13'h0200;

    // ----------------------------------------------------------------
    // pages and addresses
    // ----------------------------------------------------------------
    localparam logic [1:0] PAGE_SETUP   = 2'h0;
    localparam logic [1:0] PAGE_STATUS  = 2'h1;
    localparam logic [1:0] PAGE_ACCUM   = 2'h2;
    localparam logic [4:0] ADDR_DELAY   = 5'h01;
    localparam logic [4:0] ADDR_ID_LO   = 5'h03;
    localparam logic [4:0] ADDR_ID_HI   = 5'h04;
    localparam logic [4:0] ADDR_STATUS  = 5'h00;
    localparam logic [4:0] ADDR_CONFIG  = 5'h01;
    localparam logic [4:0] P0_RSVD_FROM = 5'h05;
    localparam logic [4:0] P1_RSVD_FROM = 5'h06;
    localparam logic [4:0] P2_RSVD_FROM = 5'h08;
    localparam logic [7:0] RD_RESERVED  = 8'hff;
    localparam logic [7:0] RD_UNUSED    = 8'h00;

    // ----------------------------------------------------------------
    // commands
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_LOCK     = 8'h43;
    localparam logic [7:0] CMD_UNLOCK   = 8'h44;
    localparam logic [7:0] CMD_RECALL   = 8'hb8;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int DLY_REL_LSB = 6;
    localparam int DLY_OVD_LSB = 4;
    localparam int DLY_UVD_LSB = 2;
    localparam int DLY_OCD_LSB = 0;
    localparam logic [7:0] DELAY_RESET = 8'h00;
    localparam int CFG_ACC = 7;
    localparam int CFG_TH_LSB = 5;
    localparam int CFG_POR = 4;
    localparam int CFG_DIR = 1;
    localparam int CFG_AVG = 0;
    localparam logic [7:0] CFG_FIXED_ONES = 8'h0c;
    localparam logic [1:0] TH_RESET = 2'h0;
    localparam logic [7:0] STAT_ZERO_TOP = 8'h00;

    typedef enum logic [0:0] {OC_WATCH, OC_RELEASE} pdt_oc_state_t;
endpackage

// ### src/pdt_hold_timer.sv
// counts ms ticks while a condition holds, flags the end
`timescale 1ns/1ns
`default_nettype none
module pdt_hold_timer
    import pdt_pkg::*;
#(
    parameter int CNT_W = MS_W
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // condition and timebase
    input  wire logic             i_cond,
    input  wire logic             i_tick,
    input  wire logic [CNT_W-1:0] i_limit,
    // result
    output logic                  o_expired
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             reached;

    // any drop of the condition restarts the whole hold time
    assign reached    = (count_reg >= i_limit);
    assign count_next = !i_cond ? '0 :
                        (i_tick && !reached) ? count_reg + 1'b1 : count_reg;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            count_reg <= '0;
            o_expired <= 1'b0;
        end else begin
            count_reg <= count_next;
            o_expired <= i_cond && reached;
        end
    end
endmodule // pdt_hold_timer
`default_nettype wire

// ### src/pdt_line_watch.sv
// syncs the bus line, flags a too-long low as a bus reset
`timescale 1ns/1ns
`default_nettype none
module pdt_line_watch
    import pdt_pkg::*;
#(
    parameter int RESET_CYCLES = BUS_RESET_CYC
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // line
    input  wire logic i_line,
    output logic      o_line,
    output logic      o_reset_pulse
);
    logic        meta_reg;
    logic        line_reg;
    logic [15:0] low_reg;
    logic        fire;

    // fires on the cycle after the limit is passed
    assign fire = !line_reg && (low_reg == 16'(RESET_CYCLES));

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_reg      <= 1'b1;
            line_reg      <= 1'b1;
            low_reg       <= '0;
            o_reset_pulse <= 1'b0;
        end else begin
            meta_reg      <= i_line;
            line_reg      <= meta_reg;
            o_reset_pulse <= fire; // see (R18)
            if (line_reg)
                low_reg <= '0;
            else if (low_reg <= 16'(RESET_CYCLES))
                low_reg <= low_reg + 16'h0001;
        end
    end

    assign o_line = line_reg;
endmodule // pdt_line_watch
`default_nettype wire

// ### src/pdt_regs_top.sv
// protection timing, status, config and identity registers
// Behaviour
// (R1) overcurrent: both paths off for release time
// (R2) overvoltage held for delay disables charging
// (R3) undervoltage held: both off, low power
// (R4) overcurrent held for delay disables that direction; code turns both charge and discharge off
// (R5) status bit seven reads zero, read-only
// (R6) status pin bit refreshed on page access
// (R7) lock flag shows page zero write protection
// (R8) status bits show live protection conditions
// (R9) warning bit set on low capacity/voltage
// (R10) config bits three, two read one
// (R11) config bit seven enables accumulators
// (R12) config bits six, five select threshold
// (R13) power-on flag sticks at one once written
// (R14) config bit one sets pin direction
// (R15) config bit zero picks average or minimum
// (R16) sixteen-bit identifier readable, never writable
// (R17) bus driven only open-drain
// (R18) bus low over 120 us resets
// (R19) paused master leaves bus high
// (R20) lock and unlock commands set, clear flag
// (R21) delay register powers up zero
// (R22) writes leave read-only bits unchanged
`timescale 1ns/1ns
`default_nettype none
module pdt_regs_top
    import pdt_pkg::*;
#(
    parameter int          MS_TICK_CYCLES = MS_CYCLES,
    parameter int          BUS_RESET_CYCLES = BUS_RESET_CYC,
    parameter logic [15:0] PACK_ID = 16'h5a3c // arbitrary value
) (
    // clock and reset
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_RESET,
    // single-wire bus pin
    input  wire logic       I_DQ_IN,
    output logic            O_DQ_OUT,
    output logic            O_DQ_OE,
    // bit engine side of the bus
    input  wire logic       I_DQ_PULL_LOW,
    output logic            O_BUS_RESET,
    // decoded commands
    input  wire logic       I_CMD_VALID,
    input  wire logic [7:0] I_CMD_CODE,
    // register access
    input  wire logic       I_ACC_READ,
    input  wire logic       I_ACC_WRITE,
    input  wire logic [1:0] I_ACC_PAGE,
    input  wire logic [4:0] I_ACC_ADDR,
    input  wire logic [7:0] I_ACC_WDATA,
    output logic            O_RD_VALID,
    output logic [7:0]      O_RD_DATA,
    // analog comparators and pin
    input  wire logic       I_OVER_VOLTAGE,
    input  wire logic       I_UNDER_VOLTAGE,
    input  wire logic       I_OVER_CURRENT_DIS,
    input  wire logic       I_OVER_CURRENT_CHG,
    input  wire logic       I_OVER_TEMP,
    input  wire logic       I_CAPACITY_LOW,
    input  wire logic       I_VOLTAGE_WARN,
    input  wire logic       I_PROG_IO_PIN,
    // protection outputs
    output logic            O_CHARGE_EN,
    output logic            O_DISCHARGE_EN,
    output logic            O_LOW_POWER,
    // configuration outputs
    output logic            O_ACCUMULATORS_ON,
    output logic [1:0]      O_ACCUM_THRESHOLD,
    output logic            O_PIO_READ_DIR,
    output logic            O_VOLTAGE_AVERAGE_SEL
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic             ov_in;
    logic             uv_in;
    logic             ocd_in;
    logic             occ_in;
    logic             ot_in;
    logic             cap_low_in;
    logic             vwarn_in;
    logic             pio_in;

    assign async_in = {I_PROG_IO_PIN, I_VOLTAGE_WARN, I_CAPACITY_LOW, I_OVER_TEMP,
                       I_OVER_CURRENT_CHG, I_OVER_CURRENT_DIS, I_UNDER_VOLTAGE,
                       I_OVER_VOLTAGE};
    assign {pio_in, vwarn_in, cap_low_in, ot_in, occ_in, ocd_in, uv_in, ov_in} = sync2_reg;

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    // ----------------------------------------------------------------
    // bus line: open-drain drive and long-low detection
    // ----------------------------------------------------------------
    logic dq_line;
    logic bus_reset;

    pdt_line_watch #(
        .RESET_CYCLES (BUS_RESET_CYCLES)
    ) u_watch (
        .i_clk         (I_CLK_SYS),
        .i_reset       (I_RESET),
        .i_line        (I_DQ_IN),
        .o_line        (dq_line),
        .o_reset_pulse (bus_reset)
    );

    // only ever pull low; the pull-up makes the high level
    assign O_DQ_OUT    = 1'b0; // see (R17)
    assign O_BUS_RESET = bus_reset;

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET)
            O_DQ_OE <= 1'b0;
        else
            O_DQ_OE <= I_DQ_PULL_LOW && no_rst(bus_reset); // see (R17)
    end

    function automatic logic no_rst(input logic rst);
        // a bus reset abandons any answer being driven
        return !rst;
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] delay_reg;
    logic       lock_reg;
    logic       pio_flag_reg;
    logic       acc_reg;
    logic [1:0] th_reg;
    logic       por_reg;
    logic       dir_reg;
    logic       avg_reg;
    logic [7:0] status_val;
    logic [7:0] config_val;

    // a bus reset in the same cycle cancels the access
    logic cmd_ok;
    logic do_lock;
    logic do_unlock;
    logic do_recall;
    logic wr_ok;
    logic wr_delay;
    logic wr_config;
    logic page1_touch;

    assign cmd_ok      = I_CMD_VALID && !bus_reset; // see (R18)
    assign do_lock     = cmd_ok && (I_CMD_CODE == CMD_LOCK);
    assign do_unlock   = cmd_ok && (I_CMD_CODE == CMD_UNLOCK);
    assign do_recall   = cmd_ok && (I_CMD_CODE == CMD_RECALL);
    assign wr_ok       = I_ACC_WRITE && !bus_reset; // see (R18)
    // page zero writes are dropped while locked
    assign wr_delay    = wr_ok && !lock_reg && (I_ACC_PAGE == PAGE_SETUP)
                         && (I_ACC_ADDR == ADDR_DELAY); // see (R7)
    assign wr_config   = wr_ok && (I_ACC_PAGE == PAGE_ACCUM) && (I_ACC_ADDR == ADDR_CONFIG);
    assign page1_touch = (I_ACC_READ || I_ACC_WRITE) && !bus_reset
                         && (I_ACC_PAGE == PAGE_STATUS);

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET)
            delay_reg <= DELAY_RESET; // see (R21)
        else if (do_recall)
            delay_reg <= DELAY_RESET; // see (R21)
        else if (wr_delay)
            delay_reg <= I_ACC_WDATA;
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET)
            lock_reg <= 1'b1; // see (R7)
        else if (do_lock)
            lock_reg <= 1'b1; // see (R20)
        else if (do_unlock)
            lock_reg <= 1'b0; // see (R20)
    end

    // the pin level is captured only when the status page is touched
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET)
            pio_flag_reg <= 1'b0;
        else if (page1_touch)
            pio_flag_reg <= pio_in; // see (R6)
    end

    // fixed bits are not stored, so writes cannot reach them
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            acc_reg <= 1'b1; // see (R11)
            th_reg  <= TH_RESET;
            dir_reg <= 1'b1; // see (R14)
            avg_reg <= 1'b1; // see (R15)
        end else if (do_recall) begin
            acc_reg <= 1'b1;
            th_reg  <= TH_RESET;
            dir_reg <= 1'b1;
            avg_reg <= 1'b1;
        end else if (wr_config) begin
            acc_reg <= I_ACC_WDATA[CFG_ACC]; // see (R11)
            th_reg  <= I_ACC_WDATA[CFG_TH_LSB +: 2]; // see (R12)
            dir_reg <= I_ACC_WDATA[CFG_DIR]; // see (R14)
            avg_reg <= I_ACC_WDATA[CFG_AVG]; // see (R15)
        end
    end

    // power-on flag: only a reset clears it, recall leaves it alone
    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET)
            por_reg <= 1'b0; // see (R13)
        else if (wr_config && I_ACC_WDATA[CFG_POR])
            por_reg <= 1'b1; // see (R13)
    end

    // ----------------------------------------------------------------
    // millisecond timebase
    // ----------------------------------------------------------------
    logic [31:0] pre_reg;
    logic        ms_tick;

    assign ms_tick = (pre_reg == 32'(MS_TICK_CYCLES - 1));

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET)
            pre_reg <= '0;
        else if (ms_tick)
            pre_reg <= '0;
        else
            pre_reg <= pre_reg + 32'h00000001;
    end

    // ----------------------------------------------------------------
    // protection delays
    // ----------------------------------------------------------------
    function automatic logic [MS_W-1:0] sel_ms(input logic [MS_W-1:0] base,
                                               input logic [1:0] sel);
        // each step of a two-bit field doubles the time
        return base << sel;
    endfunction

    logic [MS_W-1:0] ovd_ms;
    logic [MS_W-1:0] uvd_ms;
    logic [MS_W-1:0] ocd_ms;
    logic [MS_W-1:0] rel_ms;
    logic            ov_held;
    logic            uv_held;
    logic            ocd_held;
    logic            occ_held;

    assign ovd_ms = sel_ms(OVD_BASE_MS, delay_reg[DLY_OVD_LSB +: 2]); // see (R2)
    assign uvd_ms = sel_ms(UVD_BASE_MS, delay_reg[DLY_UVD_LSB +: 2]); // see (R3)
    assign ocd_ms = sel_ms(OCD_BASE_MS, delay_reg[DLY_OCD_LSB +: 2]); // see (R4)
    assign rel_ms = sel_ms(REL_BASE_MS, delay_reg[DLY_REL_LSB +: 2]); // see (R1)

    pdt_hold_timer #(.CNT_W(MS_W)) u_ov (
        .i_clk     (I_CLK_SYS),
        .i_reset   (I_RESET),
        .i_cond    (ov_in),
        .i_tick    (ms_tick),
        .i_limit   (ovd_ms),
        .o_expired (ov_held)
    );

    pdt_hold_timer #(.CNT_W(MS_W)) u_uv (
        .i_clk     (I_CLK_SYS),
        .i_reset   (I_RESET),
        .i_cond    (uv_in),
        .i_tick    (ms_tick),
        .i_limit   (uvd_ms),
        .o_expired (uv_held)
    );

    pdt_hold_timer #(.CNT_W(MS_W)) u_ocd (
        .i_clk     (I_CLK_SYS),
        .i_reset   (I_RESET),
        .i_cond    (ocd_in),
        .i_tick    (ms_tick),
        .i_limit   (ocd_ms),
        .o_expired (ocd_held)
    );

    pdt_hold_timer #(.CNT_W(MS_W)) u_occ (
        .i_clk     (I_CLK_SYS),
        .i_reset   (I_RESET),
        .i_cond    (occ_in),
        .i_tick    (ms_tick),
        .i_limit   (ocd_ms),
        .o_expired (occ_held)
    );

    // ----------------------------------------------------------------
    // overcurrent release sequence
    // ----------------------------------------------------------------
    pdt_oc_state_t   oc_state_reg;
    pdt_oc_state_t   oc_state_next;
    logic [MS_W-1:0] rel_cnt_reg;
    logic [MS_W-1:0] rel_cnt_next;
    logic            oc_trip;

    assign oc_trip = ocd_held || occ_held; // see (R4)

    always_comb begin
        oc_state_next = oc_state_reg;
        rel_cnt_next  = rel_cnt_reg;
        case (oc_state_reg)
            OC_WATCH: begin
                rel_cnt_next = '0;
                if (oc_trip)
                    oc_state_next = OC_RELEASE; // see (R1)
            end
            OC_RELEASE: begin
                // the release time runs from detection, not from recovery
                if (rel_cnt_reg >= rel_ms)
                    oc_state_next = OC_WATCH; // see (R1)
                else if (ms_tick)
                    rel_cnt_next = rel_cnt_reg + 1'b1;
            end
            default: begin
                oc_state_next = OC_WATCH;
                rel_cnt_next  = '0;
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            oc_state_reg <= OC_WATCH;
            rel_cnt_reg  <= '0;
        end else begin
            oc_state_reg <= oc_state_next;
            rel_cnt_reg  <= rel_cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // protection outputs
    // ----------------------------------------------------------------
    logic oc_flag;
    logic dtw_flag;

    assign oc_flag  = (oc_state_reg == OC_RELEASE);
    assign dtw_flag = cap_low_in || vwarn_in; // see (R9)

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            O_CHARGE_EN    <= 1'b0;
            O_DISCHARGE_EN <= 1'b0;
            O_LOW_POWER    <= 1'b0;
        end else begin
            O_CHARGE_EN    <= !(ov_held || uv_held || oc_flag || ot_in); // see (R2)
            O_DISCHARGE_EN <= !(uv_held || oc_flag || ot_in); // see (R3)
            O_LOW_POWER    <= uv_held; // see (R3)
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    assign status_val = {STAT_ZERO_TOP[7], pio_flag_reg, lock_reg, ot_in, ov_held,
                         uv_held, oc_flag, dtw_flag}; // see (R5) (R8)
    assign config_val = {acc_reg, th_reg, por_reg, 2'b00, dir_reg, avg_reg}
                        | CFG_FIXED_ONES; // see (R10) (R22)

    function automatic logic [7:0] page_fill(input logic [4:0] addr,
                                             input logic [4:0] rsvd_from);
        return (addr >= rsvd_from) ? RD_RESERVED : RD_UNUSED;
    endfunction

    logic [7:0] rd_mux;
    logic       rd_ok;

    assign rd_ok = I_ACC_READ && !bus_reset; // see (R18)

    always_comb begin
        rd_mux = RD_RESERVED;
        case (I_ACC_PAGE)
            PAGE_SETUP: begin
                if (I_ACC_ADDR == ADDR_DELAY)
                    rd_mux = delay_reg;
                else if (I_ACC_ADDR == ADDR_ID_LO)
                    rd_mux = PACK_ID[7:0]; // see (R16)
                else if (I_ACC_ADDR == ADDR_ID_HI)
                    rd_mux = PACK_ID[15:8]; // see (R16)
                else
                    rd_mux = page_fill(I_ACC_ADDR, P0_RSVD_FROM);
            end
            PAGE_STATUS: begin
                // pin bit shows the level at this access
                if (I_ACC_ADDR == ADDR_STATUS)
                    rd_mux = {status_val[7], pio_in, status_val[5:0]}; // see (R6)
                else
                    rd_mux = page_fill(I_ACC_ADDR, P1_RSVD_FROM);
            end
            PAGE_ACCUM: begin
                if (I_ACC_ADDR == ADDR_CONFIG)
                    rd_mux = config_val;
                else
                    rd_mux = page_fill(I_ACC_ADDR, P2_RSVD_FROM);
            end
            default: rd_mux = RD_UNUSED;
        endcase
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
        if (I_RESET) begin
            O_RD_VALID <= 1'b0;
            O_RD_DATA  <= '0;
        end else begin
            O_RD_VALID <= rd_ok;
            if (rd_ok)
                O_RD_DATA <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // configuration outputs
    // ----------------------------------------------------------------
    assign O_ACCUMULATORS_ON     = acc_reg; // see (R11)
    assign O_ACCUM_THRESHOLD     = th_reg; // see (R12)
    assign O_PIO_READ_DIR        = dir_reg; // see (R14)
    assign O_VOLTAGE_AVERAGE_SEL = avg_reg; // see (R15)

    logic unused_line;
    assign unused_line = dq_line;
endmodule // pdt_regs_top
`default_nettype wire

// ### sim/pdt_bus_master.sv
// bus master model: pulls the line low for a set span
`timescale 1ns/1ns
`default_nettype none
module pdt_bus_master (
    // clock and command
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [7:0] i_low_cyc,
    // open-drain pull, high = line pulled low
    output logic            o_pull
);
    logic [7:0] cnt_reg = 8'h00;
    // pulls only, never drives high: the pull-up gives the idle level
    always_ff @(posedge i_clk) begin
        if (i_go) cnt_reg <= i_low_cyc;
        else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
    end
    // released line goes back high, so a pause is not taken for a reset
    assign o_pull = (cnt_reg != 8'h00);
endmodule // pdt_bus_master
`default_nettype wire

// ### sim/pdt_regs_top_properties.sv
// port assertions for the register block
`timescale 1ns/1ns
`default_nettype none
module pdt_regs_props (
    // watched ports
    input wire logic       I_CLK_SYS,
    input wire logic       I_RESET,
    input wire logic       I_DQ_PULL_LOW,
    input wire logic       I_ACC_READ,
    input wire logic [1:0] I_ACC_PAGE,
    input wire logic [4:0] I_ACC_ADDR,
    input wire logic       O_DQ_OUT,
    input wire logic       O_DQ_OE,
    input wire logic       O_BUS_RESET,
    input wire logic       O_RD_VALID,
    input wire logic [7:0] O_RD_DATA,
    input wire logic       O_CHARGE_EN,
    input wire logic       O_DISCHARGE_EN,
    input wire logic       O_LOW_POWER
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);
    wire rd_ok = I_ACC_READ && !O_BUS_RESET;
    a_dq_out_zero: assert property (O_DQ_OUT == 1'b0)
        else $error("data pin not held low");
    a_oe_tracks_pull: assert property (!O_BUS_RESET |=> O_DQ_OE == $past(I_DQ_PULL_LOW))
        else $error("pull enable wrong");
    a_oe_off_reset: assert property (O_BUS_RESET |=> !O_DQ_OE)
        else $error("pull after bus reset");
    a_reset_pulse_once: assert property (O_BUS_RESET |=> !O_BUS_RESET [*8])
        else $error("bus reset pulse too long");
    a_read_answers: assert property (rd_ok |=> O_RD_VALID)
        else $error("read not answered");
    a_status_top_zero: assert property (rd_ok && I_ACC_PAGE == 2'h1 && I_ACC_ADDR == 5'h00
        |=> O_RD_DATA[7] == 1'b0) else $error("status top bit set");
    a_cfg_fixed_ones: assert property (rd_ok && I_ACC_PAGE == 2'h2 && I_ACC_ADDR == 5'h01
        |=> O_RD_DATA[3:2] == 2'h3) else $error("config fixed bits wrong");
    a_low_power_off: assert property (O_LOW_POWER |-> !O_CHARGE_EN && !O_DISCHARGE_EN)
        else $error("path on in low power");
endmodule // pdt_regs_props
bind pdt_regs_top pdt_regs_props u_pdt_regs_props (.*);
`default_nettype wire

// ### sim/pdt_regs_top_tb.sv
// testbench for the protection register block
`timescale 1ns/1ns
`default_nettype none
module pdt_regs_top_tb;
    localparam logic [15:0] ID = 16'h1234; // arbitrary value
    logic clk = 1'b0, rst = 1'b1, pl = 1'b0, cv = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0;
    logic [7:0] cc = 8'h00, wd = 8'h00, ml = 8'h00, rdat;
    logic [7:0] cond = 8'h01; // ov uv ocd occ ot cap vw pin
    logic [1:0] pg = 2'h0, th;
    logic [4:0] ad = 5'h00;
    logic       oe, brst, che, dche, lp, acc_o, dir, voltage_average_sel, pull;
    wire        line = !(oe | pull);
    int         n_errors = 0, checks = 0, nrst = 0;
    always #5 clk = !clk;
    always @(posedge clk) if (brst === 1'b1) nrst++;
    pdt_regs_top #(.MS_TICK_CYCLES(10), .BUS_RESET_CYCLES(20), .PACK_ID(ID)) u_pdt_regs_top (
        .I_CLK_SYS(clk), .I_RESET(rst), .I_DQ_IN(line), .O_DQ_OUT(), .O_DQ_OE(oe),
        .I_DQ_PULL_LOW(pl), .O_BUS_RESET(brst), .I_CMD_VALID(cv), .I_CMD_CODE(cc),
        .I_ACC_READ(rd), .I_ACC_WRITE(wr), .I_ACC_PAGE(pg), .I_ACC_ADDR(ad), .I_ACC_WDATA(wd),
        .O_RD_VALID(), .O_RD_DATA(rdat), .I_OVER_VOLTAGE(cond[7]), .I_UNDER_VOLTAGE(cond[6]),
        .I_OVER_CURRENT_DIS(cond[5]), .I_OVER_CURRENT_CHG(cond[4]), .I_OVER_TEMP(cond[3]),
        .I_CAPACITY_LOW(cond[2]), .I_VOLTAGE_WARN(cond[1]), .I_PROG_IO_PIN(cond[0]),
        .O_CHARGE_EN(che), .O_DISCHARGE_EN(dche), .O_LOW_POWER(lp), .O_ACCUMULATORS_ON(acc_o),
        .O_ACCUM_THRESHOLD(th), .O_PIO_READ_DIR(dir), .O_VOLTAGE_AVERAGE_SEL(voltage_average_sel));
    pdt_bus_master u_pdt_bus_master (.i_clk(clk), .i_go(go), .i_low_cyc(ml), .o_pull(pull));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // idle cycle first: a strobe never falls and rises in one step
    task automatic xfer(input logic r, input logic [1:0] p, input logic [4:0] a,
                        input logic [7:0] d);
        tick(1);
        {pg, ad, wd, rd, wr} = {p, a, d, r, !r};
        tick(1);
        {rd, wr} = 2'h0;
    endtask
    task automatic rchk(input logic [1:0] p, input logic [4:0] a, input logic [7:0] e);
        xfer(1'b1, p, a, 8'h00);
        chk(rdat, e);
    endtask
    task automatic cmd(input logic [7:0] c);
        tick(1);
        {cc, cv} = {c, 1'b1};
        tick(1);
        cv = 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        tick(4);
        rst = 1'b0;
        rchk(2'h0, 5'h01, 8'h00);
        rchk(2'h2, 5'h01, 8'h8f);
        rchk(2'h1, 5'h00, 8'h60);
        rchk(2'h0, 5'h03, ID[7:0]);
        rchk(2'h0, 5'h04, ID[15:8]);
        rchk(2'h0, 5'h1f, 8'hff);
        rchk(2'h3, 5'h00, 8'h00);
        xfer(1'b0, 2'h0, 5'h01, 8'h5a);
        rchk(2'h0, 5'h01, 8'h00);
        cmd(8'h44);
        cond = 8'h00;
        xfer(1'b0, 2'h0, 5'h01, 8'h5a);
        xfer(1'b0, 2'h0, 5'h03, 8'hff);
        xfer(1'b0, 2'h1, 5'h00, 8'hff);
        rchk(2'h1, 5'h00, 8'h00);
        rchk(2'h0, 5'h01, 8'h5a);
        rchk(2'h0, 5'h03, ID[7:0]);
        cmd(8'h43);
        xfer(1'b0, 2'h0, 5'h01, 8'h00);
        rchk(2'h0, 5'h01, 8'h5a);
        cmd(8'h44);
        xfer(1'b0, 2'h2, 5'h01, 8'h00);
        rchk(2'h2, 5'h01, 8'h0c);
        chk({acc_o, th, dir, voltage_average_sel, 3'h0}, 8'h00);
        xfer(1'b0, 2'h2, 5'h01, 8'hf3);
        rchk(2'h2, 5'h01, 8'hff);
        chk({acc_o, th, dir, voltage_average_sel, 3'h0}, 8'hf8);
        xfer(1'b0, 2'h2, 5'h01, 8'h00);
        rchk(2'h2, 5'h01, 8'h1c);
        cmd(8'hb8);
        rchk(2'h2, 5'h01, 8'h9f);
        xfer(1'b0, 2'h0, 5'h01, 8'h01);
        cond = 8'h20;
        tick(25);
        chk({che, dche, 6'h0}, 8'hc0);
        tick(35);
        chk({che, dche, 6'h0}, 8'h00);
        rchk(2'h1, 5'h00, 8'h02);
        cond = 8'h00;
        tick(4400);
        chk({che, dche, 6'h0}, 8'h00);
        tick(800);
        chk({che, dche, 6'h0}, 8'hc0);
        cond = 8'h40;
        tick(290);
        chk({lp, 7'h0}, 8'h00);
        tick(60);
        chk({lp, che, dche, 5'h0}, 8'h80);
        rchk(2'h1, 5'h00, 8'h04);
        cond = 8'h8a;
        tick(8);
        rchk(2'h1, 5'h00, 8'h11);
        cond = 8'h80;
        tick(5200);
        chk({che, dche, 6'h0}, 8'h40);
        rchk(2'h1, 5'h00, 8'h08);
        cond = 8'h00;
        {ml, go} = {8'h28, 1'b1};
        tick(1);
        go = 1'b0;
        tick(60);
        chk(nrst[7:0], 8'h01);
        {ml, go} = {8'h0a, 1'b1};
        tick(1);
        {go, pl} = 2'h1;
        tick(3);
        pl = 1'b0;
        tick(30);
        chk(nrst[7:0], 8'h01);
        tally_and_finish;
    end
endmodule // pdt_regs_top_tb
`default_nettype wire
